// file: design/lane_flags_pkg.sv
// Constants shared by the lane error status block
package lane_flags_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Sizes
  localparam int NUM_LANES = 8;
  localparam int NUM_LINKS = 2;
  localparam int CNT_W = 8;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 16;
  localparam int IDX_W = 12;
  localparam int IRQ_W = 3;
  localparam int LINK_PAGE_W = 1;

  ////////////////////////////////////////////////////////////////////////////////
  // Register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LINK_PAGE = 12'h300;
  localparam logic [IDX_W-1:0] IDX_ALIGN = 12'h46c;
  localparam logic [IDX_W-1:0] IDX_DISP = 12'h46d;
  localparam logic [IDX_W-1:0] IDX_INV = 12'h46e;
  localparam logic [IDX_W-1:0] IDX_THRESH = 12'h47c;
  localparam logic [IDX_W-1:0] IDX_CTRL = 12'h47d;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 12'h47e;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 12'h47f;

  localparam logic [ADDR_W-1:0] ADDR_LINK_PAGE = {2'b00, IDX_LINK_PAGE, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_ALIGN = {2'b00, IDX_ALIGN, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_DISP = {2'b00, IDX_DISP, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INV = {2'b00, IDX_INV, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_THRESH = {2'b00, IDX_THRESH, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_CTRL = {2'b00, IDX_CTRL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {2'b00, IDX_IRQ_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = {2'b00, IDX_IRQ_MASK, 2'b00};

  ////////////////////////////////////////////////////////////////////////////////
  // Field positions
  localparam int LINK_PAGE_LSB = 0;
  localparam int CTRL_CLR_BIT = 0;
  localparam int IRQ_DISP_BIT = 0;
  localparam int IRQ_INV_BIT = 1;
  localparam int IRQ_ALIGN_BIT = 2;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [CNT_W-1:0] THRESH_RST = 8'h01;
  localparam logic [LINK_PAGE_W-1:0] LINK_PAGE_RST = 1'h0;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

endpackage

// file: design/err_lane_counter.sv
// Saturating per-lane error counter with threshold flag
`timescale 1ns/100ps
module err_lane_counter #(
  parameter int CNT_W = lane_flags_pkg::CNT_W
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic evt, // One error seen this cycle
  input wire logic clr, // Clear the count
  input wire logic [CNT_W-1:0] thresh, // Error threshold
  output logic flag // Count at or above threshold
);
  import lane_flags_pkg::*;

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic flag;
  } cnt_state_t;

  cnt_state_t s_q;
  cnt_state_t s_d;

  always_comb begin
    s_d = s_q;
    if (clr) begin
      s_d.cnt = '0;
    end else if (evt && s_q.cnt != '1) begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
    s_d.flag = (s_d.cnt >= thresh);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign flag = s_q.flag;

  flag_at_thresh_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.cnt >= $past(thresh)) |-> s_q.flag)
    else $error("flag low with count at or above threshold");

  flag_below_thresh_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.cnt < $past(thresh)) |-> !s_q.flag)
    else $error("flag high with count below threshold");

  count_step_a: assert property (@(posedge pclk) disable iff (!presetn)
    (evt && !clr && s_q.cnt != '1) |=> (s_q.cnt == $past(s_q.cnt) + 1'b1))
    else $error("error event not counted");

endmodule

// file: design/irq_status_regs.sv
// Sticky interrupt status with mask and level output
`timescale 1ns/100ps
module irq_status_regs #(
  parameter int W = lane_flags_pkg::IRQ_W
) (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, active low
  input wire logic [W-1:0] evt, // Event pulses
  input wire logic clr_we, // Write one to clear status
  input wire logic mask_we, // Mask write
  input wire logic [W-1:0] wdata, // Write data
  output logic [W-1:0] status, // Sticky status
  output logic [W-1:0] mask, // Interrupt enables
  output logic irq // Level interrupt
);
  import lane_flags_pkg::*;

  typedef struct packed {
    logic [W-1:0] status;
    logic [W-1:0] mask;
    logic irq;
  } irq_state_t;

  irq_state_t s_q;
  irq_state_t s_d;

  always_comb begin
    s_d = s_q;
    // New events win over a clear in the same cycle
    s_d.status = (s_q.status & ~(clr_we ? wdata : '0)) | evt;
    if (mask_we) begin
      s_d.mask = wdata;
    end
    s_d.irq = |(s_d.status & s_d.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{status: '0, mask: IRQ_MASK_RST, irq: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign status = s_q.status;
  assign mask = s_q.mask;
  assign irq = s_q.irq;

  set_wins_a: assert property (@(posedge pclk) disable iff (!presetn)
    (evt != '0) |=> ((s_q.status & $past(evt)) == $past(evt)))
    else $error("event lost against clear");

endmodule

// file: design/lane_error_status_flags.sv
// APB status block for lane deskew and 8b/10b error flags, paged per link
`timescale 1ns/100ps

//////////////////////////////////////////////////////////////////////////////////
// Contract
// - Lane 0 alignment bit reads 1 when deskew achieved, 0 when failed.
// - Eight-bit read-only disparity flag vector, bit n for lane n.
// - Eight-bit read-only invalid code flag vector, bit n for lane n.
// - A flag reads 1 when its count is at or above the threshold.
// - A flag reads 0 while its count stays below the threshold.
// - Flag registers are banked per link; reads return the selected page.
module lane_error_status_flags #(
  parameter int NUM_LANES = lane_flags_pkg::NUM_LANES,
  parameter int NUM_LINKS = lane_flags_pkg::NUM_LINKS
) (
  input wire logic pclk, // APB clock, 40 MHz
  input wire logic presetn, // Async reset, active low
  input wire logic [lane_flags_pkg::ADDR_W-1:0] paddr, // Byte address
  input wire logic psel, // Slave select
  input wire logic penable, // Access phase
  input wire logic pwrite, // Write when high
  input wire logic [lane_flags_pkg::DATA_W-1:0] pwdata, // Write data
  input wire logic [3:0] pstrb, // Byte strobes
  output logic [lane_flags_pkg::DATA_W-1:0] prdata, // Read data
  output logic pready, // Transfer done
  output logic pslverr, // Unmapped address
  input wire logic [NUM_LINKS*NUM_LANES-1:0] disp_err_evt, // Disparity error pulses
  input wire logic [NUM_LINKS*NUM_LANES-1:0] invalid_code_evt, // Not-in-table pulses
  input wire logic [NUM_LINKS*NUM_LANES-1:0] lane_aligned, // Deskew achieved levels
  output logic irq // Level interrupt
);
  import lane_flags_pkg::*;

  localparam int TOTAL = NUM_LINKS * NUM_LANES;

  ////////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pslverr;
    logic [LINK_PAGE_W-1:0] link_page;
    logic [CNT_W-1:0] thresh;
    logic clr;
    logic [TOTAL-1:0] disp_prev;
    logic [TOTAL-1:0] inv_prev;
    logic [NUM_LINKS-1:0] align0_prev;
  } slave_state_t;

  slave_state_t s_q;
  slave_state_t s_d;

  logic setup;
  logic access;
  logic wr_en;
  logic [TOTAL-1:0] disp_flag;
  logic [TOTAL-1:0] inv_flag;
  logic [NUM_LINKS-1:0] align0;
  logic [NUM_LANES-1:0] paged_align;
  logic [NUM_LANES-1:0] paged_disp;
  logic [NUM_LANES-1:0] paged_inv;
  logic [IRQ_W-1:0] irq_evt;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic irq_clr_we;
  logic irq_mask_we;
  logic [DATA_W-1:0] rd_data;
  logic rd_err;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phases

  assign setup = psel && !penable;
  assign access = psel && penable;
  // Every register lives in byte lane 0
  assign wr_en = access && pwrite && pstrb[0];
  assign pready = 1'b1;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;

  ////////////////////////////////////////////////////////////////////////////////
  // Error counters, one per lane and error type on every link

  for (genvar i = 0; i < TOTAL; i++) begin : g_lane
    err_lane_counter #(
      .CNT_W(CNT_W)
    ) u_disp_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .evt(disp_err_evt[i]),
      .clr(s_q.clr),
      .thresh(s_q.thresh),
      .flag(disp_flag[i])
    );

    err_lane_counter #(
      .CNT_W(CNT_W)
    ) u_inv_cnt (
      .pclk(pclk),
      .presetn(presetn),
      .evt(invalid_code_evt[i]),
      .clr(s_q.clr),
      .thresh(s_q.thresh),
      .flag(inv_flag[i])
    );
  end

  for (genvar l = 0; l < NUM_LINKS; l++) begin : g_link
    assign align0[l] = lane_aligned[l*NUM_LANES];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Page selection

  always_comb begin
    paged_align = lane_aligned[int'(s_q.link_page)*NUM_LANES +: NUM_LANES];
    paged_disp = disp_flag[int'(s_q.link_page)*NUM_LANES +: NUM_LANES];
    paged_inv = inv_flag[int'(s_q.link_page)*NUM_LANES +: NUM_LANES];
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt events

  always_comb begin
    irq_evt = '0;
    irq_evt[IRQ_DISP_BIT] = |(disp_flag & ~s_q.disp_prev);
    irq_evt[IRQ_INV_BIT] = |(inv_flag & ~s_q.inv_prev);
    irq_evt[IRQ_ALIGN_BIT] = |(s_q.align0_prev & ~align0);
  end

  assign irq_clr_we = wr_en && paddr == ADDR_IRQ_STATUS;
  assign irq_mask_we = wr_en && paddr == ADDR_IRQ_MASK;

  irq_status_regs #(
    .W(IRQ_W)
  ) u_irq (
    .pclk(pclk),
    .presetn(presetn),
    .evt(irq_evt),
    .clr_we(irq_clr_we),
    .mask_we(irq_mask_we),
    .wdata(pwdata[IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Read decode

  always_comb begin
    rd_data = '0;
    rd_err = 1'b0;
    case (paddr)
      ADDR_LINK_PAGE: begin
        rd_data[LINK_PAGE_LSB +: LINK_PAGE_W] = s_q.link_page;
      end
      ADDR_ALIGN: begin
        rd_data[NUM_LANES-1:0] = paged_align;
      end
      ADDR_DISP: begin
        rd_data[NUM_LANES-1:0] = paged_disp;
      end
      ADDR_INV: begin
        rd_data[NUM_LANES-1:0] = paged_inv;
      end
      ADDR_THRESH: begin
        rd_data[CNT_W-1:0] = s_q.thresh;
      end
      ADDR_CTRL: begin
        rd_data = '0;
      end
      ADDR_IRQ_STATUS: begin
        rd_data[IRQ_W-1:0] = irq_status;
      end
      ADDR_IRQ_MASK: begin
        rd_data[IRQ_W-1:0] = irq_mask;
      end
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    s_d = s_q;
    s_d.clr = 1'b0;
    s_d.disp_prev = disp_flag;
    s_d.inv_prev = inv_flag;
    s_d.align0_prev = align0;
    // Answer captured at setup so it comes from flops in the access phase
    if (setup) begin
      s_d.prdata = pwrite ? '0 : rd_data;
      s_d.pslverr = rd_err;
    end
    if (wr_en) begin
      if (paddr == ADDR_LINK_PAGE) begin
        s_d.link_page = pwdata[LINK_PAGE_LSB +: LINK_PAGE_W];
      end
      if (paddr == ADDR_THRESH) begin
        s_d.thresh = pwdata[CNT_W-1:0];
      end
      if (paddr == ADDR_CTRL) begin
        s_d.clr = pwdata[CTRL_CLR_BIT];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{
        prdata: '0,
        pslverr: 1'b0,
        link_page: LINK_PAGE_RST,
        thresh: THRESH_RST,
        clr: 1'b0,
        disp_prev: '0,
        inv_prev: '0,
        align0_prev: '0
      };
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  align_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ADDR_ALIGN) |=> (prdata[0] == $past(paged_align[0])))
    else $error("lane 0 alignment bit wrong");

  disp_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ADDR_DISP)
      |=> (prdata == {{(DATA_W-NUM_LANES){1'b0}}, $past(paged_disp)}))
    else $error("disparity flags read wrong");

  inv_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ADDR_INV)
      |=> (prdata == {{(DATA_W-NUM_LANES){1'b0}}, $past(paged_inv)}))
    else $error("invalid code flags read wrong");

  page_select_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_LINK_PAGE)
      |=> (s_q.link_page == $past(pwdata[LINK_PAGE_LSB +: LINK_PAGE_W])))
    else $error("link page not applied");

  clear_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (s_q.clr && s_q.thresh != '0) |=> ((disp_flag | inv_flag) == '0))
    else $error("counter clear left a flag set");

  unmapped_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && rd_err) |=> (pslverr && prdata == '0))
    else $error("unmapped access not flagged");

  ////////////////////////////////////////////////////////////////////////////////
  // Per-link page checks, slices taken straight from lane_aligned and the flag vectors

  for (genvar l = 0; l < NUM_LINKS; l++) begin : g_page_chk
    page_align_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == ADDR_ALIGN && int'(s_q.link_page) == l)
        |=> (prdata[NUM_LANES-1:0] == $past(lane_aligned[l*NUM_LANES +: NUM_LANES])))
      else $error("alignment page read wrong");

    page_disp_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == ADDR_DISP && int'(s_q.link_page) == l)
        |=> (prdata[NUM_LANES-1:0] == $past(disp_flag[l*NUM_LANES +: NUM_LANES])))
      else $error("disparity page read wrong");

    page_inv_a: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !pwrite && paddr == ADDR_INV && int'(s_q.link_page) == l)
        |=> (prdata[NUM_LANES-1:0] == $past(inv_flag[l*NUM_LANES +: NUM_LANES])))
      else $error("invalid code page read wrong");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and holds

  thresh_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && paddr == ADDR_THRESH) |=> (s_q.thresh == $past(pwdata[CNT_W-1:0])))
    else $error("threshold write lost");

  thresh_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == ADDR_THRESH) |=> (s_q.thresh == $past(s_q.thresh)))
    else $error("threshold changed without write");

  page_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !(wr_en && paddr == ADDR_LINK_PAGE) |=> (s_q.link_page == $past(s_q.link_page)))
    else $error("link page changed without write");

  strobe_ignore_a: assert property (@(posedge pclk) disable iff (!presetn)
    (access && pwrite && !pstrb[0])
      |=> (s_q.thresh == $past(s_q.thresh) && s_q.link_page == $past(s_q.link_page)))
    else $error("write without strobe took effect");

  ro_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && (paddr == ADDR_DISP || paddr == ADDR_INV))
      |=> (!pslverr && s_q.thresh == $past(s_q.thresh)))
    else $error("flag register write not ignored");

  unmapped_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && rd_err)
      |=> (s_q.thresh == $past(s_q.thresh) && s_q.link_page == $past(s_q.link_page)
        && irq_mask == $past(irq_mask)))
    else $error("unmapped write changed a register");

  clr_from_ctrl_a: assert property (@(posedge pclk) disable iff (!presetn)
    s_q.clr |-> $past(wr_en && paddr == ADDR_CTRL && pwdata[CTRL_CLR_BIT]))
    else $error("counter clear without control write");

  ////////////////////////////////////////////////////////////////////////////////
  // Read answers

  read_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    !setup |=> (prdata == $past(prdata) && pslverr == $past(pslverr)))
    else $error("read answer changed outside setup");

  thresh_read_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ADDR_THRESH)
      |=> (prdata == {{(DATA_W-CNT_W){1'b0}}, $past(s_q.thresh)}))
    else $error("threshold read wrong");

  ctrl_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !pwrite && paddr == ADDR_CTRL) |=> (prdata == '0))
    else $error("control register read not zero");

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt sources

  disp_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((disp_flag & ~s_q.disp_prev) != '0) |=> irq_status[IRQ_DISP_BIT])
    else $error("disparity flag rise not latched");

  inv_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((inv_flag & ~s_q.inv_prev) != '0) |=> irq_status[IRQ_INV_BIT])
    else $error("invalid code flag rise not latched");

  align_event_a: assert property (@(posedge pclk) disable iff (!presetn)
    ((s_q.align0_prev & ~align0) != '0) |=> irq_status[IRQ_ALIGN_BIT])
    else $error("alignment loss not latched");

  mask_write_a: assert property (@(posedge pclk) disable iff (!presetn)
    irq_mask_we |=> (irq_mask == $past(pwdata[IRQ_W-1:0])))
    else $error("interrupt mask write lost");

  irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
    1'b1 |-> (irq == |(irq_status & irq_mask)))
    else $error("interrupt level wrong");

endmodule

// file: tb/lane_tx_model.sv
// Far-end transmitter model driving lane error pulses and deskew levels
`timescale 1ns/100ps
module lane_tx_model (
  input wire logic pclk, // Clock
  output logic [15:0] disp_err_evt, // Disparity error pulses
  output logic [15:0] invalid_code_evt, // Invalid code pulses
  output logic [15:0] lane_aligned // Deskew levels
);
  initial begin
    disp_err_evt = '0;
    invalid_code_evt = '0;
    lane_aligned = '0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Back-to-back error pulses on one lane
  task automatic burst(input bit inv, input int idx, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (inv) begin
        invalid_code_evt[idx] <= 1'b1;
      end else begin
        disp_err_evt[idx] <= 1'b1;
      end
    end
    @(posedge pclk);
    disp_err_evt <= '0;
    invalid_code_evt <= '0;
  endtask

  task automatic align(input logic [15:0] v);
    @(posedge pclk);
    lane_aligned <= v;
  endtask
endmodule

// file: tb/lane_error_status_flags_test.sv
// Self-checking bench for the lane error status block
`timescale 1ns/100ps
module lane_error_status_flags_test;
  import lane_flags_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [3:0] strb = 4'hf;
  logic [DATA_W-1:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [15:0] disp_evt;
  logic [15:0] inv_evt;
  logic [15:0] aligned;
  logic [31:0] rd;
  logic [31:0] rnd = 32'hc92b;
  logic err;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int disp_cnt[16];
  int inv_cnt[16];
  int thr;
  int link;
  int lane;

  always #12.5 pclk = ~pclk;

  lane_error_status_flags dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .disp_err_evt(disp_evt), .invalid_code_evt(inv_evt),
    .lane_aligned(aligned), .irq(irq));

  lane_tx_model tx (.pclk(pclk), .disp_err_evt(disp_evt), .invalid_code_evt(inv_evt),
    .lane_aligned(aligned));

  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  function automatic logic [31:0] exp_flags(input bit inv, input int lk);
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 8; i++) begin
      v[i] = (inv ? inv_cnt[lk*8+i] : disp_cnt[lk*8+i]) >= thr;
    end
    return v;
  endfunction

  task automatic end_sim();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    pstrb <= strb;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    apb(1'b0, a, '0);
    chk(rd, exp);
    chk({31'h0, err}, 32'h0000_0000);
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      end_sim();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int i = 0; i < 16; i++) begin
      disp_cnt[i] = 0;
      inv_cnt[i] = 0;
    end
    thr = 1;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ADDR_DISP, 32'h0000_0000);
    rdchk(ADDR_INV, 32'h0000_0000);
    rdchk(ADDR_ALIGN, 32'h0000_0000);
    rdchk(ADDR_THRESH, 32'h0000_0001);
    rdchk(ADDR_CTRL, 32'h0000_0000);
    apb(1'b0, 16'h0004, '0);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b0, ADDR_DISP + 16'h0001, '0);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 16'h0004, 32'h0000_00ff);
    chk({31'h0, err}, 32'h0000_0001);
    apb(1'b1, ADDR_DISP, 32'h0000_00ff);
    chk({31'h0, err}, 32'h0000_0000);
    strb = 4'he;
    apb(1'b1, ADDR_THRESH, 32'h0000_0055);
    strb = 4'hf;
    rdchk(ADDR_THRESH, 32'h0000_0001);
    rdchk(ADDR_DISP, 32'h0000_0000);
    tx.align(16'h0001);
    tx.align(16'h0000);
    repeat (2) @(posedge pclk);
    rdchk(ADDR_IRQ_STATUS, 32'h0000_0004);
    apb(1'b1, ADDR_IRQ_MASK, 32'h0000_0001);
    for (int it = 0; it < 6; it++) begin
      rnd = lfsr(rnd);
      link = int'(rnd[0]);
      lane = int'(rnd[3:1]);
      thr = 2 + int'(rnd[6:4]) % 6;
      apb(1'b1, ADDR_CTRL, 32'h0000_0001);
      repeat (3) @(posedge pclk);
      for (int i = 0; i < 16; i++) begin
        disp_cnt[i] = 0;
        inv_cnt[i] = 0;
      end
      apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0007);
      apb(1'b1, ADDR_THRESH, 32'(thr));
      rdchk(ADDR_THRESH, 32'(thr));
      apb(1'b1, ADDR_LINK_PAGE, 32'(link));
      tx.burst(1'b0, link*8+lane, thr-1);
      disp_cnt[link*8+lane] += thr-1;
      rdchk(ADDR_DISP, exp_flags(1'b0, link));
      tx.burst(1'b0, link*8+lane, 1);
      disp_cnt[link*8+lane]++;
      rdchk(ADDR_DISP, exp_flags(1'b0, link));
      rdchk(ADDR_IRQ_STATUS, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0000_0001);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h0000_0001);
      tx.burst(1'b1, link*8+lane, thr);
      inv_cnt[link*8+lane] += thr;
      rdchk(ADDR_INV, exp_flags(1'b1, link));
      chk({31'h0, irq}, 32'h0000_0000);
      apb(1'b1, ADDR_LINK_PAGE, 32'(1 - link));
      rdchk(ADDR_DISP, exp_flags(1'b0, 1 - link));
      rdchk(ADDR_INV, exp_flags(1'b1, 1 - link));
      rnd = lfsr(rnd);
      tx.align(rnd[15:0]);
      rdchk(ADDR_ALIGN, 32'(rnd[(1-link)*8 +: 8]));
    end
    apb(1'b1, ADDR_THRESH, 32'h0000_0000);
    thr = 0;
    repeat (2) @(posedge pclk);
    rdchk(ADDR_DISP, exp_flags(1'b0, 1 - link));
    end_sim();
  end
endmodule
